/* File: rsu_image_select.sv */
// Image selection logic with an APB register file.
// Assumes synchronous inputs and an external controller on the pins.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps

module rsu_image_select
  import rsu_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        ERROR_STATUS_LINE_N_I,
  input  wire logic        CONFIGURATION_COMPLETE_I,
  input  wire logic        CRC_ERROR_I,
  input  wire logic        USER_WATCHDOG_RESET_I,
  input  wire logic        WATCHDOG_TIMEOUT_I,
  input  wire logic        SHIFT_DATA_I,
  output logic             SHIFT_DATA_O,
  output logic             CORE_RESET_O,
  output logic [2:0]       PAGE_SELECT_LINES_O,
  output logic             PAGE_SELECT_LINES_OE_O,
  output logic [23:0]      FLASH_START_ADDRESS_O,
  output logic             LOAD_REQ_O,
  output logic             IRQ_O
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  rsu_state_t  state, next_state;
  logic [31:0] control, next_control;
  logic [11:0] wd_value, next_wd_value;
  logic        wd_en, next_wd_en;
  logic [6:0]  page, next_page;
  logic        app_flag, next_app_flag;
  logic [4:0]  cause, next_cause;
  logic [11:0] par_data, next_par_data;
  logic [1:0]  lat, next_lat;
  logic [IRQ_W-1:0] irq_stat, next_irq_stat;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [23:0] start_addr, next_start_addr;
  logic        err_q, next_err_q;
  logic [31:0] prdata, next_prdata;
  logic [IRQ_W-1:0] events;

  logic wr_en;
  logic rd_en;
  logic fail;
  logic [2:0] sel;

  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_en = PSEL_I & PENABLE_I & ~PWRITE_I;
  assign sel   = control[PAR_SEL_LO +: 3];

  // Falling error line
  // A held-low line counts once, on its falling edge.
  assign events[IRQ_ERR]  = err_q & ~ERROR_STATUS_LINE_N_I;
  assign events[IRQ_WDOG] = WATCHDOG_TIMEOUT_I & wd_en;
  assign events[IRQ_DONE] = CONFIGURATION_COMPLETE_I & (state == ST_LOAD);
  assign events[IRQ_CRC]  = CRC_ERROR_I;
  // Fallback always on
  // There is no option to disable fallback; every failure loads FACTORY_ADDR, but in the page scheme the page lines keep page[2:0].
  assign fail = |{events[IRQ_ERR], events[IRQ_WDOG], events[IRQ_CRC]};

  function automatic logic [23:0] page_to_addr(input logic [6:0] pg,
                                               input logic [1:0] dens);
    logic [23:0] a;
    a = 24'h000000;
    if (dens == DENS_16)
      a = {3'h0, pg[4:0], 16'h0000};
    else if (dens == DENS_4)
      a = {5'h00, pg[2:0], 16'h0000};
    else
      a = {1'b0, pg, 16'h0000};
    return a;
  endfunction

  function automatic logic [11:0] param_value(input logic [2:0] s,
                                              input logic [4:0] c,
                                              input logic [11:0] wv,
                                              input logic we,
                                              input logic [6:0] pg,
                                              input logic af);
    logic [11:0] v;
    v = 12'h000;
    if (s == SEL_STATUS)
      v = {7'h00, c};
    else if (s == SEL_WD_VALUE)
      v = wv;
    else if (s == SEL_WD_EN)
      v = {11'h000, we};
    else if (s == SEL_PAGE)
      v = {5'h00, pg};
    else if (s == SEL_APP_FLAG)
      v = {11'h000, af};
    return v;
  endfunction

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb
  begin
    next_state      = state;
    next_control    = control;
    next_wd_value   = wd_value;
    next_wd_en      = wd_en;
    next_page       = page;
    next_app_flag   = app_flag;
    next_cause      = cause;
    next_par_data   = par_data;
    next_lat        = lat;
    next_start_addr = start_addr;
    next_err_q      = ERROR_STATUS_LINE_N_I;
    next_irq_mask   = irq_mask;
    next_irq_stat   = irq_stat;
    next_prdata     = prdata;
    next_control[CTL_RECONFIG] = 1'b0;
    next_control[CTL_READ]     = 1'b0;
    next_control[CTL_WRITE]    = 1'b0;
    if (wr_en && PADDR_I == OFS_CONTROL)
      next_control = PWDATA_I;
    else if (wr_en && PADDR_I == OFS_IRQ_MASK)
      next_irq_mask = PWDATA_I[IRQ_W-1:0];
    else if (wr_en && PADDR_I == OFS_IRQ_STAT)
      next_irq_stat = irq_stat & ~PWDATA_I[IRQ_W-1:0];
    // Set wins over a clear in the same cycle.
    next_irq_stat = next_irq_stat | events;
    case (state)
      ST_IDLE:
      begin
        if (control[CTL_READ])
        begin
          next_state = ST_BUSY;
          next_lat   = 2'(READ_LAT - 1);
        end
        else if (control[CTL_WRITE] && !app_flag)
        begin
          // Flag not writable
          // Writes reach only factory-writable fields.
          if (sel == SEL_WD_VALUE)
            next_wd_value = control[31:20];
          else if (sel == SEL_WD_EN)
            next_wd_en = control[20];
          else if (sel == SEL_PAGE)
            next_page = control[26:20];
        end
        else if (control[CTL_RECONFIG])
        begin
          next_state = ST_LOAD;
          next_app_flag = 1'b1;
          next_start_addr = page_to_addr(page, control[CTL_DENS_LO +: 2]);
        end
      end
      ST_BUSY:
      begin
        if (lat == 2'h0)
        begin
          next_par_data = param_value(sel, cause, wd_value, wd_en,
                                      page, app_flag);
          next_state = ST_IDLE;
        end
        else
          next_lat = lat - 2'h1;
      end
      ST_LOAD:
      begin
        if (CONFIGURATION_COMPLETE_I)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
    if (fail)
    begin
      next_app_flag   = 1'b0;
      next_start_addr = FACTORY_ADDR;
      next_state      = ST_LOAD;
      next_cause      = {1'b0, events[IRQ_WDOG], 1'b0,
                         events[IRQ_ERR], events[IRQ_CRC]};
    end
    next_prdata = 32'h00000000;
    if (PSEL_I && !PWRITE_I)
    begin
      if (PADDR_I == OFS_CONTROL)
        next_prdata = control;
      else if (PADDR_I == OFS_PARAM)
        next_prdata = {20'h00000, par_data};
      else if (PADDR_I == OFS_PAGE)
        next_prdata = {25'h0000000, page};
      else if (PADDR_I == OFS_STATUS)
        next_prdata = {24'h000000, 3'h0, app_flag, cause[3:0]} |
                      {30'h00000000, state == ST_BUSY, 1'b0} << 8;
      else if (PADDR_I == OFS_IRQ_STAT)
        next_prdata = {28'h0000000, irq_stat};
      else if (PADDR_I == OFS_IRQ_MASK)
        next_prdata = {28'h0000000, irq_mask};
      else if (PADDR_I == OFS_ADDR)
        next_prdata = {8'h00, start_addr};
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      state      <= ST_IDLE;
      control    <= 32'h00000000;
      wd_value   <= RST_WD_VALUE;
      wd_en      <= 1'b0;
      page       <= RST_PAGE;
      app_flag   <= 1'b0;
      cause      <= 5'h00;
      par_data   <= 12'h000;
      lat        <= 2'h0;
      start_addr <= FACTORY_ADDR;
      err_q      <= 1'b1;
      irq_stat   <= 4'h0;
      irq_mask   <= 4'h0;
      prdata     <= 32'h00000000;
    end
    else
    begin
      state      <= next_state;
      control    <= next_control;
      wd_value   <= next_wd_value;
      wd_en      <= next_wd_en;
      page       <= next_page;
      app_flag   <= next_app_flag;
      cause      <= next_cause;
      par_data   <= next_par_data;
      lat        <= next_lat;
      start_addr <= next_start_addr;
      err_q      <= next_err_q;
      irq_stat   <= next_irq_stat;
      irq_mask   <= next_irq_mask;
      prdata     <= next_prdata;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // Setup-phase read capture gives a zero-wait access phase.
  assign PRDATA_O  = prdata;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = 1'b0;
  assign IRQ_O     = |(irq_stat & irq_mask);
  assign SHIFT_DATA_O = SHIFT_DATA_I ^ app_flag;
  assign CORE_RESET_O = fail | USER_WATCHDOG_RESET_I;
  assign PAGE_SELECT_LINES_O    = control[CTL_AS_SCHEME] ? 3'h0 : page[2:0];
  assign PAGE_SELECT_LINES_OE_O = ~control[CTL_AS_SCHEME];
  assign FLASH_START_ADDRESS_O  = control[CTL_AS_SCHEME] ? start_addr :
                                  24'h000000;
  assign LOAD_REQ_O = (state == ST_LOAD);

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  sequence s_read_req;
    state == ST_IDLE && control[CTL_READ] && !fail;
  endsequence

  property p_busy_read;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      s_read_req |=> state == ST_BUSY ##1 state == ST_BUSY ##1
      state == ST_IDLE;
  endproperty
  a_busy_read: assert property (p_busy_read)
    else $error("Parameter read did not complete in two cycles.");

  property p_fallback;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      fail |=> !app_flag && state == ST_LOAD;
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("Failure did not return to the factory image.");

  property p_factory_zero;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      !app_flag |-> start_addr == FACTORY_ADDR;
  endproperty
  a_factory_zero: assert property (p_factory_zero)
    else $error("Factory image start address not zero.");

  property p_serial_pins;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      control[CTL_AS_SCHEME] |-> !PAGE_SELECT_LINES_OE_O;
  endproperty
  a_serial_pins: assert property (p_serial_pins)
    else $error("Page lines driven in serial scheme.");

  property p_flag_read;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      state == ST_BUSY && lat == 2'h0 && sel == SEL_APP_FLAG && !fail
      |=> par_data == {11'h000, $past(app_flag)};
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("Application flag read back wrong.");

  property p_low_bits;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      start_addr[15:0] == 16'h0000;
  endproperty
  a_low_bits: assert property (p_low_bits)
    else $error("Start address low bits not zero.");

  property p_err_pulse;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      $fell(ERROR_STATUS_LINE_N_I) |-> CORE_RESET_O ##1 !app_flag;
  endproperty
  a_err_pulse: assert property (p_err_pulse)
    else $error("Error line pulse did not load factory.");

  property p_crc;
    @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
      CRC_ERROR_I |=> irq_stat[IRQ_CRC] && cause[0];
  endproperty
  a_crc: assert property (p_crc)
    else $error("Frame check error not recorded.");

endmodule

/* File: rsu_pkg.sv */
// Package of constants for the remote upgrade image selector.
// Assumes a single 40 MHz system clock and an APB master of 32-bit data.
package rsu_pkg;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_PARAM    = 8'h04;
  localparam logic [7:0] OFS_PAGE     = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_ADDR     = 8'h18;

  // ---------------------------------------------------------------------
  // Parameter selector codes and field positions
  // ---------------------------------------------------------------------
  localparam logic [2:0] SEL_STATUS   = 3'h0;
  localparam logic [2:0] SEL_ILL_1    = 3'h1;
  localparam logic [2:0] SEL_WD_VALUE = 3'h2;
  localparam logic [2:0] SEL_WD_EN    = 3'h3;
  localparam logic [2:0] SEL_PAGE     = 3'h4;
  localparam logic [2:0] SEL_APP_FLAG = 3'h5;
  localparam logic [2:0] SEL_ILL_6    = 3'h6;
  localparam logic [2:0] SEL_ILL_7    = 3'h7;

  localparam int CTL_RECONFIG  = 0;
  localparam int CTL_READ      = 1;
  localparam int CTL_WRITE     = 2;
  localparam int CTL_AS_SCHEME = 3;
  localparam int CTL_DENS_LO   = 4;
  localparam int PAR_SEL_LO    = 12;
  localparam int PAR_DATA_W    = 12;

  localparam int IRQ_ERR    = 0;
  localparam int IRQ_WDOG   = 1;
  localparam int IRQ_DONE   = 2;
  localparam int IRQ_CRC    = 3;
  localparam int IRQ_W      = 4;

  // Density codes: 0 -> 64 Mbit, 1 -> 16 Mbit, 2 -> 4 Mbit.
  localparam logic [1:0] DENS_64 = 2'h0;
  localparam logic [1:0] DENS_16 = 2'h1;
  localparam logic [1:0] DENS_4  = 2'h2;

  localparam logic [11:0] RST_WD_VALUE = 12'h000;
  localparam logic [6:0]  RST_PAGE     = 7'h00;
  localparam logic [23:0] FACTORY_ADDR = 24'h000000;
  localparam int          READ_LAT     = 2;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_LOAD = 2'b10
  } rsu_state_t;

endpackage

/* File: rsu_cfg_ctrl_model.sv */
// Behavioural external configuration controller facing the image selector.
// Assumes load request and page lines are synchronous to the system clock.
`timescale 1ns/10ps

module rsu_cfg_ctrl_model
  import rsu_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       load_req_i,
  input  wire logic [2:0] page_i,
  input  wire logic       page_oe_i,
  input  wire logic       fail_i,
  output logic            complete_o,
  output logic            error_n_o,
  output logic [2:0]      seen_page_o
);
  logic [3:0] cnt;
  logic       erred;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt         <= 4'h0;
      erred       <= 1'b0;
      complete_o  <= 1'b0;
      error_n_o   <= 1'b1;
      seen_page_o <= 3'h0;
    end
    else if (!load_req_i)
    begin
      cnt        <= 4'h0;
      erred      <= 1'b0;
      complete_o <= 1'b0;
      error_n_o  <= 1'b1;
    end
    else
    begin
      if (cnt != 4'hA)
        cnt <= cnt + 4'h1;
      if (cnt == 4'h0 && page_oe_i)
        seen_page_o <= page_i;
      if (cnt == 4'h6 && fail_i && !erred)
        error_n_o <= 1'b0;
      if (cnt == 4'h8 && fail_i && !erred)
      begin
        error_n_o <= 1'b1;
        erred     <= 1'b1;
        cnt       <= 4'h1;
      end
      // A failed image never releases completion, only the retry does.
      if (cnt == 4'h9 && (!fail_i || erred))
        complete_o <= 1'b1;
    end
  end
endmodule

/* File: rsu_image_select_tb_top.sv */
// Self-checking bench for the image selector with a controller model.
// Assumes an APB slave; the master waits for ready however long it takes.
`timescale 1ns/10ps

module rsu_image_select_tb_top
  import rsu_pkg::*;
;
  typedef struct packed
  {
    logic [1:0]  d;
    logic [6:0]  p;
    logic [23:0] a;
  } rsu_tb_row_t;

  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        err_n, complete, crc_err, wd_rst, shift_i, shift_o;
  logic        core_rst, page_oe, load_req, irq, fail, wd_to;
  logic [2:0]  page_lines, seen_page;
  logic [23:0] start_addr;
  int          num_errors, n_compared, cyc, n;
  rsu_tb_row_t rows [4] = '{'{DENS_64, 7'h55, 24'h550000},
                            '{DENS_16, 7'h7F, 24'h1F0000},
                            '{DENS_4, 7'h7D, 24'h050000},
                            '{DENS_64, 7'h00, 24'h000000}};

  rsu_image_select rsu_image_select_inst (
    .CLK_SYS_I(clk_sys), .RESET_N_I(reset_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .ERROR_STATUS_LINE_N_I(err_n),
    .CONFIGURATION_COMPLETE_I(complete), .CRC_ERROR_I(crc_err),
    .USER_WATCHDOG_RESET_I(wd_rst), .WATCHDOG_TIMEOUT_I(wd_to),
    .SHIFT_DATA_I(shift_i), .SHIFT_DATA_O(shift_o),
    .CORE_RESET_O(core_rst), .PAGE_SELECT_LINES_O(page_lines),
    .PAGE_SELECT_LINES_OE_O(page_oe), .FLASH_START_ADDRESS_O(start_addr),
    .LOAD_REQ_O(load_req), .IRQ_O(irq));

  rsu_cfg_ctrl_model rsu_cfg_ctrl_model_inst (
    .clk_i(clk_sys), .rst_n_i(reset_n), .load_req_i(load_req),
    .page_i(page_lines), .page_oe_i(page_oe), .fail_i(fail),
    .complete_o(complete), .error_n_o(err_n), .seen_page_o(seen_page));

  always #12.5 clk_sys = ~clk_sys;

  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Read data is taken at the edge that samples ready, never earlier.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic wait_load(input logic v);
    int k;
    k = 0;
    @(negedge clk_sys);
    while (load_req !== v && k < 100)
    begin
      @(negedge clk_sys);
      k++;
    end
    chk(32'(load_req), 32'(v));
  endtask

  // Fallback through a frame check error; the image must end in factory.
  task automatic crc_pulse();
    @(posedge clk_sys);
    crc_err <= 1'b1;
    @(posedge clk_sys);
    crc_err <= 1'b0;
    wait_load(1'b0);
  endtask

  // The page is a parameter write, so it only lands from the factory image.
  task automatic boot(input logic [1:0] d, input logic [6:0] p,
                      input logic as);
    wr(OFS_CONTROL, (32'(p) << 20) | (32'(SEL_PAGE) << PAR_SEL_LO) | 32'h4);
    wr(OFS_CONTROL, (32'(as) << CTL_AS_SCHEME)
                    | (32'(d) << CTL_DENS_LO) | 32'h1);
    wait_load(1'b1);
  endtask

  task automatic par(input logic [2:0] s, output logic [31:0] r);
    int k;
    wr(OFS_CONTROL, 32'h8 | (32'(s) << PAR_SEL_LO) | 32'h2);
    k = 0;
    r = 32'h200;
    while (r[9] !== 1'b0 && k < 20)
    begin
      apb(1'b0, OFS_STATUS, 32'h0, r);
      k++;
    end
    apb(1'b0, OFS_PARAM, 32'h0, r);
  endtask

  initial
  begin
    {clk_sys, reset_n, psel, penable, pwrite, crc_err} = 6'h00;
    {wd_rst, shift_i, fail, wd_to} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {num_errors, n_compared, cyc} = {32'd0, 32'd0, 32'd0};
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    chk(32'(load_req), 32'h0);
    chk(32'(start_addr), 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0, q);
    chk(q, 32'h0);
    wr(OFS_CONTROL, 32'h00100000 | (32'(SEL_WD_EN) << PAR_SEL_LO) | 32'h4);
    wr(OFS_CONTROL, 32'h00100000 | (32'(SEL_APP_FLAG) << PAR_SEL_LO)
                    | 32'h4);
    par(SEL_APP_FLAG, q);
    chk(q, 32'h0);
    par(SEL_WD_EN, q);
    chk(q, 32'h1);
    foreach (rows[i])
    begin
      boot(rows[i].d, rows[i].p, 1'b1);
      chk(32'(start_addr), 32'(rows[i].a));
      chk(32'(page_oe), 32'h0);
      wait_load(1'b0);
      apb(1'b0, OFS_STATUS, 32'h0, q);
      chk(32'(q[4]), 32'h1);
      crc_pulse();
      apb(1'b0, OFS_STATUS, 32'h0, q);
      chk(32'(q[4]), 32'h0);
    end
    boot(DENS_64, 7'h06, 1'b0);
    chk(32'(page_oe), 32'h1);
    chk(32'(page_lines), 32'h6);
    wait_load(1'b0);
    chk(32'(seen_page), 32'h6);
    par(SEL_APP_FLAG, q);
    chk(q, 32'h1);
    @(posedge clk_sys);
    shift_i <= 1'b1;
    wd_rst  <= 1'b1;
    @(negedge clk_sys);
    chk(32'(shift_o), 32'h0);
    chk(32'(core_rst), 32'h1);
    @(posedge clk_sys);
    wd_rst <= 1'b0;
    wd_to  <= 1'b1;
    @(posedge clk_sys);
    wd_to  <= 1'b0;
    wait_load(1'b0);
    apb(1'b0, OFS_STATUS, 32'h0, q);
    chk(32'(q[4]), 32'h0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0, q);
    chk(32'(q[IRQ_WDOG]), 32'h1);
    fail <= 1'b1;
    boot(DENS_64, 7'h55, 1'b1);
    n = 0;
    while (err_n !== 1'b0 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    repeat (4) @(negedge clk_sys);
    chk(32'(start_addr), 32'h0);
    wait_load(1'b0);
    apb(1'b0, OFS_STATUS, 32'h0, q);
    chk(32'(q[4]), 32'h0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0, q);
    chk(32'(q[IRQ_ERR]), 32'h1);
    fail <= 1'b0;
    chk(32'(irq), 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
    @(negedge clk_sys);
    chk(32'(irq), 32'h1);
    wr(OFS_IRQ_STAT, 32'hF);
    @(negedge clk_sys);
    chk(32'(irq), 32'h0);
    apb(1'b0, 8'h3C, 32'h0, q);
    chk(q, 32'h0);
    tally_and_finish();
  end
endmodule
